/* rtl/scr_pkg.sv */
// constants, encodings and carriers for the calibration pattern readout
// assumes commands arrive already sampled on sys_clk, one per cycle
//
// Contract
// - With pattern mode on, no read uses the array; only location 00b serves the pattern.
// - MR3 A[1:0] 00b gives the calibration pattern; other codes are reserved.
// - In pattern mode a read with auto-precharge performs no precharge.
// - Reset still works while pattern mode is on.
// - With A2 low, reads and writes use the array; A[1:0] ignored.
// - Lane bit 0 of each byte carries the pattern; others copy it or zero.
// - Pattern reads ignore bank, A[9:3], A10, A11 and other high bits.
// - BL8 returns beats 0..7; chopped reads pick lower or upper half by A2.
// - A12 selects chop on the fly only when MR0 allows; fixed chop also works.
// - Pattern reads use the same latency and timing as array reads.
// - Burst position 0 is the pattern LSB, position 7 the MSB.
// - Pattern alternates 0,1 starting with 0, for full and chopped bursts.
// - Chip select low with RAS, CAS, WE high is a no-operation.
// - Chip select high deselects; no command taken, bursts go on.
package scr_pkg;
	// --------------------------------------------------------------
	// command decode
	// --------------------------------------------------------------
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] BANK_MR0 = 3'h0;
	localparam logic [2:0] BANK_MR3 = 3'h3;

	// --------------------------------------------------------------
	// mode register fields
	// --------------------------------------------------------------
	localparam int MR3_MPR_BIT = 2;
	localparam int MR0_BL_LSB = 0;
	localparam int ADDR_NIB_BIT = 2;
	localparam int ADDR_AP_BIT = 10;
	localparam int ADDR_BC_BIT = 12;
	localparam logic [1:0] LOC_PATTERN = 2'h0;
	localparam logic [1:0] BL_FIX8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIX4 = 2'h2;
	localparam logic [2:0] MR3_RESET = 3'h0;
	localparam logic [1:0] MR0_BL_RESET = 2'h0;

	// --------------------------------------------------------------
	// burst
	// --------------------------------------------------------------
	localparam logic [2:0] LAST_BL8 = 3'h7;
	localparam logic [2:0] LAST_BC4 = 3'h3;
	localparam logic [2:0] BEAT_FIRST = 3'h0;
	localparam logic [2:0] BEAT_STEP = 3'h1;

	// --------------------------------------------------------------
	// carriers
	// --------------------------------------------------------------
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} scr_cmd_type;

	typedef struct packed {
		logic mpr;
		logic [1:0] loc;
		logic bc4;
		logic nib;
	} scr_entry_type;

	localparam int ENTRY_W = 5;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_BURST = 2'b10
	} scr_state_type;
endpackage

/* rtl/scr_readout.sv */
// read command queue and the device-side readout engine
// assumes cmd, ba and addr are sampled on sys_clk; one beat per cycle
`timescale 1ns/100ps

// --------------------------------------------------------------
// small fifo
// --------------------------------------------------------------
module scr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] CNT_MAX = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] PTR_MAX = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
		ptr_next = (p == PTR_MAX) ? '0 : p + 1'b1;
	endfunction

	assign in_ready = (cnt_q != CNT_MAX);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_d = push ? ptr_next(wr_q) : wr_q;
		rd_d = pop ? ptr_next(rd_q) : rd_q;
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (ce && push) begin
			mem_q[wr_q] <= in_data;
		end
	end
endmodule

// --------------------------------------------------------------
// readout top
// --------------------------------------------------------------
module scr_readout #(
	parameter int READ_LAT = 5,
	parameter int QUEUE_DEPTH = 4,
	parameter bit LANE_REPLICATE = 1'b1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	// command and address
	input wire scr_pkg::scr_cmd_type cmd,
	input wire logic [2:0] ba,
	input wire logic [12:0] addr,
	// array side
	input wire logic [15:0] arr_rd_data,
	output logic arr_rd_strobe,
	output logic arr_wr_strobe,
	output logic arr_precharge,
	// data lanes
	output logic [15:0] dq_out,
	output logic dq_oe,
	output logic dqs_out,
	// status
	output logic cmd_stall,
	output logic mpr_active
);
	localparam int LW = $clog2(READ_LAT + 1);
	localparam logic [LW-1:0] LAT_LOAD = LW'(READ_LAT - 1);

	// ----------------------------------------------------------
	// command decode
	// ----------------------------------------------------------
	logic [2:0] op;
	logic sel, is_nop, is_mrs, is_rd, is_wr;

	assign sel = !cmd.cs_n;
	assign op = {cmd.ras_n, cmd.cas_n, cmd.we_n};
	assign is_nop = sel && (op == scr_pkg::CMD_NOP);
	assign is_mrs = sel && (op == scr_pkg::CMD_MRS);
	assign is_rd = sel && (op == scr_pkg::CMD_RD);
	assign is_wr = sel && (op == scr_pkg::CMD_WR);

	// ----------------------------------------------------------
	// mode registers
	// ----------------------------------------------------------
	logic [2:0] mr3_q, mr3_d;
	logic [1:0] bl_q, bl_d;
	logic mpr_on;

	assign mpr_on = mr3_q[scr_pkg::MR3_MPR_BIT];

	always_comb begin
		mr3_d = mr3_q;
		bl_d = bl_q;
		if (is_mrs && ba == scr_pkg::BANK_MR3) begin
			mr3_d = addr[2:0];
		end
		if (is_mrs && ba == scr_pkg::BANK_MR0) begin
			bl_d = addr[scr_pkg::MR0_BL_LSB +: 2];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mr3_q <= scr_pkg::MR3_RESET;
			bl_q <= scr_pkg::MR0_BL_RESET;
		end else if (ce) begin
			mr3_q <= mr3_d;
			bl_q <= bl_d;
		end
	end

	// ----------------------------------------------------------
	// read queue
	// ----------------------------------------------------------
	scr_pkg::scr_entry_type ent_in, ent_out;
	logic q_ready, q_valid, q_pop, chop;
	logic [scr_pkg::ENTRY_W-1:0] q_data;

	// only pattern mode, location, chop and A2 survive; bank and other bits dropped
	always_comb begin
		chop = (bl_q == scr_pkg::BL_FIX4)
			|| (bl_q == scr_pkg::BL_OTF && !addr[scr_pkg::ADDR_BC_BIT]);
		ent_in.mpr = mpr_on;
		ent_in.loc = mr3_q[1:0];
		ent_in.bc4 = chop;
		ent_in.nib = chop && addr[scr_pkg::ADDR_NIB_BIT];
	end

	assign ent_out = scr_pkg::scr_entry_type'(q_data);

	scr_fifo #(
		.WIDTH(scr_pkg::ENTRY_W),
		.DEPTH(QUEUE_DEPTH)
	) u_queue (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.in_valid(is_rd),
		.in_ready(q_ready),
		.in_data(ent_in),
		.out_valid(q_valid),
		.out_ready(q_pop),
		.out_data(q_data)
	);

	// ----------------------------------------------------------
	// burst engine
	// ----------------------------------------------------------
	scr_pkg::scr_state_type st_q, st_d;
	scr_pkg::scr_entry_type cur_q, cur_d;
	logic [LW-1:0] lat_q, lat_d;
	logic [2:0] beat_q, beat_d;
	logic last;

	assign q_pop = (st_q == scr_pkg::ST_IDLE) && q_valid;
	assign last = (beat_q == (cur_q.bc4 ? scr_pkg::LAST_BC4 : scr_pkg::LAST_BL8));

	// one latency path for array and pattern reads
	always_comb begin
		st_d = st_q;
		cur_d = cur_q;
		lat_d = lat_q;
		beat_d = beat_q;
		case (st_q)
			scr_pkg::ST_IDLE: begin
				if (q_valid) begin
					cur_d = ent_out;
					lat_d = LAT_LOAD;
					st_d = scr_pkg::ST_WAIT;
				end
			end
			scr_pkg::ST_WAIT: begin
				if (lat_q == '0) begin
					beat_d = scr_pkg::BEAT_FIRST;
					st_d = scr_pkg::ST_BURST;
				end else begin
					lat_d = lat_q - 1'b1;
				end
			end
			scr_pkg::ST_BURST: begin
				beat_d = beat_q + scr_pkg::BEAT_STEP;
				if (last) begin
					st_d = scr_pkg::ST_IDLE;
				end
			end
			default: begin
				st_d = scr_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_q <= scr_pkg::ST_IDLE;
			cur_q <= '0;
			lat_q <= '0;
			beat_q <= scr_pkg::BEAT_FIRST;
		end else if (ce) begin
			st_q <= st_d;
			cur_q <= cur_d;
			lat_q <= lat_d;
			beat_q <= beat_d;
		end
	end

	// ----------------------------------------------------------
	// beat data
	// ----------------------------------------------------------
	function automatic logic [7:0] lane_fill(input logic b);
		lane_fill = LANE_REPLICATE ? {8{b}} : {7'h00, b};
	endfunction

	logic [2:0] pos;
	logic pat_bit, in_burst, pat_src;

	assign in_burst = (st_q == scr_pkg::ST_BURST);
	assign pat_src = cur_q.mpr && (cur_q.loc == scr_pkg::LOC_PATTERN);
	// chopped upper half starts at position 4
	assign pos = cur_q.bc4 ? {cur_q.nib, beat_q[1:0]} : beat_q;
	assign pat_bit = pat_src && pos[0];

	// ----------------------------------------------------------
	// output registers
	// ----------------------------------------------------------
	logic [15:0] dq_q, dq_d;
	logic oe_q, oe_d, dqs_q, dqs_d, ard_q, ard_d;
	logic awr_q, awr_d, pre_q, pre_d, stall_q, stall_d;
	logic pat_beat_q, pat_beat_d, rfu_beat_q, rfu_beat_d;

	always_comb begin
		oe_d = in_burst;
		dqs_d = in_burst && !beat_q[0];
		dq_d = '0;
		if (in_burst) begin
			dq_d = cur_q.mpr ? {lane_fill(pat_bit), lane_fill(pat_bit)} : arr_rd_data;
		end
		ard_d = in_burst && !cur_q.mpr;
		awr_d = is_wr && !mpr_on;
		pre_d = is_rd && !mpr_on && addr[scr_pkg::ADDR_AP_BIT];
		stall_d = !q_ready;
		pat_beat_d = in_burst && pat_src;
		rfu_beat_d = in_burst && cur_q.mpr && !pat_src;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dq_q <= '0;
			oe_q <= 1'b0;
			dqs_q <= 1'b0;
			ard_q <= 1'b0;
			awr_q <= 1'b0;
			pre_q <= 1'b0;
			stall_q <= 1'b0;
			pat_beat_q <= 1'b0;
			rfu_beat_q <= 1'b0;
		end else if (ce) begin
			dq_q <= dq_d;
			oe_q <= oe_d;
			dqs_q <= dqs_d;
			ard_q <= ard_d;
			awr_q <= awr_d;
			pre_q <= pre_d;
			stall_q <= stall_d;
			pat_beat_q <= pat_beat_d;
			rfu_beat_q <= rfu_beat_d;
		end
	end

	assign dq_out = dq_q;
	assign dq_oe = oe_q;
	assign dqs_out = dqs_q;
	assign arr_rd_strobe = ard_q;
	assign arr_wr_strobe = awr_q;
	assign arr_precharge = pre_q;
	assign cmd_stall = stall_q;
	assign mpr_active = mpr_on;

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	a_nop_no_entry: assert property (@(posedge sys_clk) disable iff (rst || !ce)
		is_nop |=> (u_queue.cnt_q <= $past(u_queue.cnt_q)))
		else $error("nop queued a read");

	a_desel_no_write: assert property (@(posedge sys_clk) disable iff (rst || !ce)
		cmd.cs_n |=> !arr_wr_strobe && !arr_precharge)
		else $error("deselect acted as a command");

	a_mpr_no_array: assert property (@(posedge sys_clk) disable iff (rst || !ce)
		(in_burst && cur_q.mpr) |=> !arr_rd_strobe && dq_oe)
		else $error("pattern read touched the array");

	a_rda_no_precharge: assert property (@(posedge sys_clk) disable iff (rst || !ce)
		(is_rd && mpr_on) |=> !arr_precharge)
		else $error("precharge during pattern mode");

	a_normal_uses_array: assert property (@(posedge sys_clk) disable iff (rst || !ce)
		(in_burst && !cur_q.mpr) |=> arr_rd_strobe && dq_out == $past(arr_rd_data))
		else $error("array read not passed through");

	a_rfu_lanes_zero: assert property (@(posedge sys_clk) disable iff (rst || !ce)
		rfu_beat_q |-> dq_out == 16'h0000)
		else $error("reserved source drove data");

	a_lane_copy: assert property (@(posedge sys_clk) disable iff (rst || !ce)
		pat_beat_q |-> dq_out[7:0] == dq_out[15:8] && (dq_out[7:1] == '0 || dq_out[7:1] == {7{dq_out[0]}}))
		else $error("lane mapping wrong");

	a_pattern_alt: assert property (@(posedge sys_clk) disable iff (rst || !ce)
		($rose(dq_oe) && pat_beat_q) |-> !dq_out[0] ##1 dq_out[0] ##1 !dq_out[0] ##1 dq_out[0])
		else $error("pattern not 0,1,0,1");

	a_bc4_len: assert property (@(posedge sys_clk) disable iff (rst || !ce)
		(st_q == scr_pkg::ST_WAIT && lat_q == '0 && cur_q.bc4) |=> ##1 dq_oe [*4] ##1 !dq_oe)
		else $error("chopped burst length wrong");

	a_bl8_len: assert property (@(posedge sys_clk) disable iff (rst || !ce)
		(st_q == scr_pkg::ST_WAIT && lat_q == '0 && !cur_q.bc4) |=> ##1 dq_oe [*8] ##1 !dq_oe)
		else $error("full burst length wrong");

	a_reset_clears: assert property (@(posedge sys_clk)
		rst |=> !mpr_active && !dq_oe)
		else $error("reset did not clear pattern mode");
endmodule

/* verif/scr_ctrl_model.sv */
// controller model driving the command bus of the readout block
// assumes the bench calls issue from one process, one call at a time
`timescale 1ns/100ps

module scr_ctrl_model (
	// clock
	input wire logic sys_clk,
	// command and address
	output scr_pkg::scr_cmd_type cmd,
	output logic [2:0] ba,
	output logic [12:0] addr
);
	// --------------------------------------------------------------
	// command issue
	// --------------------------------------------------------------
	initial begin
		cmd = {1'b0, scr_pkg::CMD_NOP};
		ba = 3'h0;
		addr = 13'h0000;
	end

	// banks never opened and lock assumed from reset on
	task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
		@(posedge sys_clk);
		cmd <= c;
		ba <= b;
		addr <= a;
		@(posedge sys_clk);
		// nop between commands; address lines show garbage
		cmd <= {1'b0, scr_pkg::CMD_NOP};
		ba <= ~b;
		addr <= ~a;
		#1;
	endtask
endmodule

/* verif/scr_readout_tb_top.sv */
// self-checking bench for the calibration pattern readout
// assumes the controller model in scr_ctrl_model.sv
`timescale 1ns/100ps

module scr_readout_tb_top;
	localparam int RL = 2;
	localparam logic [3:0] C_RD = {1'b0, scr_pkg::CMD_RD};
	localparam logic [3:0] C_WR = {1'b0, scr_pkg::CMD_WR};
	localparam logic [3:0] C_MRS = {1'b0, scr_pkg::CMD_MRS};
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	scr_pkg::scr_cmd_type cmd;
	logic [2:0] ba;
	logic [12:0] addr;
	logic [15:0] arr_rd_data = 16'h0000;
	logic [15:0] dq_out;
	logic arr_rd_strobe, arr_wr_strobe, arr_precharge, dq_oe, dqs_out, cmd_stall, mpr_active;
	logic seen_wr = 1'b0;
	logic seen_pre = 1'b0;
	logic seen_oe = 1'b0;
	logic oe_was = 1'b0;
	int n_bursts = 0;
	int n_errors = 0;
	int samples_checked = 0;
	int lat_arr;
	int lat_pat;

	// --------------------------------------------------------------
	// clock, array data, monitors
	// --------------------------------------------------------------
	always #50 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		arr_rd_data <= arr_rd_data + 16'h1357;
		if (arr_wr_strobe === 1'b1) seen_wr <= 1'b1;
		if (arr_precharge === 1'b1) seen_pre <= 1'b1;
		if (dq_oe === 1'b1) seen_oe <= 1'b1;
		if (dq_oe === 1'b1 && oe_was !== 1'b1) n_bursts <= n_bursts + 1;
		oe_was <= dq_oe;
	end

	scr_ctrl_model i_ctrl (.sys_clk(sys_clk), .cmd(cmd), .ba(ba), .addr(addr));

	scr_readout #(.READ_LAT(RL), .QUEUE_DEPTH(4), .LANE_REPLICATE(1'b1)) i_dut (
		.sys_clk(sys_clk), .rst(rst), .ce(ce), .cmd(cmd), .ba(ba), .addr(addr),
		.arr_rd_data(arr_rd_data), .arr_rd_strobe(arr_rd_strobe), .arr_wr_strobe(arr_wr_strobe),
		.arr_precharge(arr_precharge), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
		.cmd_stall(cmd_stall), .mpr_active(mpr_active)
	);

	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	task automatic print_verdict();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic clr();
		seen_wr = 1'b0;
		seen_pre = 1'b0;
		seen_oe = 1'b0;
		n_bursts = 0;
	endtask

	// mode 0 pattern, 1 zeros, 2 array data
	task automatic burst(input logic [12:0] a, input int n, input int mode, output int lat);
		logic [15:0] prev;
		logic [15:0] e;
		i_ctrl.issue(C_RD, 3'h7, a);
		lat = 0;
		prev = arr_rd_data;
		while (dq_oe !== 1'b1 && lat < 40) begin
			prev = arr_rd_data;
			@(posedge sys_clk);
			#1;
			lat++;
		end
		for (int i = 0; i < n; i++) begin
			e = (mode == 2) ? prev : ((mode == 0 && i[0]) ? 16'hFFFF : 16'h0000);
			chk("dq_oe", 16'h0001, {15'h0, dq_oe});
			chk("dq_out", e, dq_out);
			chk("dqs_out", {15'h0, ~i[0]}, {15'h0, dqs_out});
			chk("arr_rd_strobe", {15'h0, mode == 2}, {15'h0, arr_rd_strobe});
			prev = arr_rd_data;
			@(posedge sys_clk);
			#1;
		end
		chk("burst_end", 16'h0000, {15'h0, dq_oe});
		repeat (RL + 3) @(posedge sys_clk);
		#1;
	endtask

	// leave pattern mode, set burst field, then write mr3
	task automatic mode_set(input logic [1:0] bl, input logic [2:0] mr3);
		i_ctrl.issue(C_MRS, scr_pkg::BANK_MR3, 13'h0000);
		i_ctrl.issue(C_MRS, scr_pkg::BANK_MR0, {11'h0, bl});
		i_ctrl.issue(C_MRS, scr_pkg::BANK_MR3, {10'h0, mr3});
	endtask

	// --------------------------------------------------------------
	// sequence
	// --------------------------------------------------------------
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk("mpr_active", 16'h0000, {15'h0, mpr_active});
		clr();
		burst(13'h0003, 8, 2, lat_arr);
		i_ctrl.issue(C_WR, 3'h1, 13'h0010);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("wr_strobe", 16'h0001, {15'h0, seen_wr});
		i_ctrl.issue(C_MRS, scr_pkg::BANK_MR3, 13'h0004);
		chk("mpr_active", 16'h0001, {15'h0, mpr_active});
		clr();
		burst(13'h0FF8, 8, 0, lat_pat);
		chk("precharge", 16'h0000, {15'h0, seen_pre});
		chk("latency", lat_arr[15:0], lat_pat[15:0]);
		mode_set(scr_pkg::BL_FIX4, 3'h4);
		burst(13'h0000, 4, 0, lat_pat);
		burst(13'h0004, 4, 0, lat_pat);
		mode_set(scr_pkg::BL_OTF, 3'h4);
		burst(13'h0000, 4, 0, lat_pat);
		burst(13'h1000, 8, 0, lat_pat);
		for (int k = 1; k < 4; k++) begin
			mode_set(scr_pkg::BL_OTF, {1'b1, k[1:0]});
			burst(13'h1000, 8, 1, lat_pat);
		end
		i_ctrl.issue(C_MRS, scr_pkg::BANK_MR3, 13'h0003);
		// array read with auto-precharge in normal mode
		clr();
		burst(13'h1400, 8, 2, lat_pat);
		chk("precharge_array", 16'h0001, {15'h0, seen_pre});
		i_ctrl.issue(C_MRS, scr_pkg::BANK_MR3, 13'h0004);
		@(posedge sys_clk);
		rst <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk("mpr_active", 16'h0000, {15'h0, mpr_active});
		burst(13'h0000, 8, 2, lat_pat);
		// one read starts a burst, four fill the queue, the sixth is dropped
		clr();
		for (int k = 0; k < 6; k++) begin
			i_ctrl.issue(C_RD, 3'h0, 13'h0000);
		end
		chk("cmd_stall", 16'h0001, {15'h0, cmd_stall});
		repeat (80) @(posedge sys_clk);
		#1;
		chk("cmd_stall_end", 16'h0000, {15'h0, cmd_stall});
		chk("bursts", 16'h0005, n_bursts[15:0]);
		clr();
		i_ctrl.issue({1'b1, scr_pkg::CMD_MRS}, scr_pkg::BANK_MR3, 13'h0004);
		i_ctrl.issue({1'b1, scr_pkg::CMD_WR}, 3'h0, 13'h0000);
		i_ctrl.issue({1'b0, scr_pkg::CMD_NOP}, 3'h0, 13'h0000);
		i_ctrl.issue({1'b1, scr_pkg::CMD_RD}, 3'h0, 13'h0000);
		repeat (RL + 12) @(posedge sys_clk);
		#1;
		chk("mpr_active", 16'h0000, {15'h0, mpr_active});
		chk("wr_strobe", 16'h0000, {15'h0, seen_wr});
		chk("dq_oe_idle", 16'h0000, {15'h0, seen_oe});
		print_verdict();
	end

	initial begin
		repeat (5000) @(posedge sys_clk);
		n_errors++;
		print_verdict();
	end
endmodule
